// file: hw/asrp_consts.vh
// constants for the serial readout and power control block
`ifndef ASRP_CONSTS_VH
`define ASRP_CONSTS_VH
`define ASRP_RES_DEFAULT     5'd12
`define ASRP_FRAME_LEN       5'd16
`define ASRP_GLITCH_EDGES    5'd2
`define ASRP_PD_EDGES        5'd10
`define ASRP_LEAD_ZEROS      5'd2
`define ASRP_MODE_NORMAL     3'b001
`define ASRP_MODE_PARTIAL    3'b010
`define ASRP_MODE_FULL       3'b100
`define ASRP_MAX_SCLK_MHZ    48
`define ASRP_FULL_PU_NS      1000
`define ASRP_CLK_MHZ         20
`define ASRP_FULL_PU_CYC     ((`ASRP_FULL_PU_NS*`ASRP_CLK_MHZ+999)/1000)
`endif

// file: hw/asrp_sync3.v
// three flip-flop synchroniser with second/third agreement filter
`timescale 1ns/1ps
module asrp_sync3 #(
    parameter RESET_VAL = 1'b0
) (
    input  wire clock,    // block clock
    input  wire reset_n,  // async reset, active low
    input  wire asyncIn,  // pin from outside the domain
    output reg  syncOut   // filtered level
);
    reg s1Q;
    reg s2Q;
    reg s3Q;

    // the filtered level only moves once stages two and three agree
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s1Q     <= RESET_VAL;
            s2Q     <= RESET_VAL;
            s3Q     <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            s1Q <= asyncIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
            if (s2Q == s3Q) begin
                syncOut <= s3Q;
            end
        end
    end
endmodule // asrp_sync3

// file: hw/asrp_readout.v
// serial readout and power-state control of the converter
// How it works
// RL1 - one dummy cycle leaves partial power-down
// RL2 - host waits quiet time after dummy
// RL3 - host waits 1 us after full wake
// RL4 - track resumes on first clock edge
// RL5 - host runs dummy cycle after supply-up
// RL6 - two dummy cycles hold partial power-down; here a second early-rise frame from partial enters full
// RL7 - three dummy cycles reach full power-down; here two early-rise frames from normal reach full
// RL8 - power-down only below 600 kSPS
// RL9 - start fall holds, samples, drives line
// RL10 - 12-bit: 14 clocks, track after 13
// RL11 - 12-bit: early rise aborts, releases line
// RL12 - 12-bit: two trailing zeros, release at 16
// RL13 - 10-bit: 12 clocks, track after 11
// RL14 - 10-bit: early rise aborts, releases line
// RL15 - 10-bit: four trailing zeros, release at 16
// RL16 - 8-bit: 10 clocks, track after 9
// RL17 - 8-bit: early rise powers down
// RL18 - 8-bit: six trailing zeros, release at 16
// RL19 - 14-clock frame drops trailing zeros
// RL20 - first zero on start fall, then shift
// RL21 - last bit driven on 15th fall
// RL22 - host may sample on rising edges
// RL23 - rise before second fall keeps normal
// RL24 - rise in 2..10 enters partial power-down
// RL25 - partial plus early rise enters full
// RL26 - rise after tenth keeps power, aborts
// RL27 - count clock falls from start fall
`timescale 1ns/1ps
`include "asrp_consts.vh"
module asrp_readout #(
    parameter [4:0] RES_BITS = `ASRP_RES_DEFAULT  // 12, 10 or 8
) (
    input  wire        clock,          // 20 MHz block clock
    input  wire        reset_n,        // async reset, active low
    input  wire        convStart_n,    // conversion-start pin, active low
    input  wire        serialClk,      // serial clock pin from host
    input  wire [11:0] sampleValue,    // converter core result, msb aligned
    output reg         serialResultOut,   // data line level
    output reg         serialResultOe,    // data line drive enable
    output reg         trackMode,      // track-and-hold tracking
    output reg         sampleStrobe,   // one-cycle sample pulse
    output reg  [2:0]  powerMode,      // one-hot power state
    output reg         fullyPowered    // analog ready for valid data
);
    // conversion length in clocks for the variant
    localparam [4:0] CONV_CLKS = RES_BITS + `ASRP_LEAD_ZEROS;
    localparam [4:0] TRACK_AFTER = CONV_CLKS - 5'd1;
    localparam integer PU_CYC_I = `ASRP_FULL_PU_CYC;
    localparam [7:0] PU_CYC = PU_CYC_I[7:0];

    wire csSync;
    wire sclkSync;
    reg  csPrev_q;
    reg  sclkPrev_q;
    reg  [4:0]  fallCnt_q;
    reg  [11:0] shift_q;
    reg  active_q;
    reg  wokeFromFull_q;
    reg  [7:0] puCnt_q;
    reg  firstEdgeSeen_q;

    asrp_sync3 #(.RESET_VAL(1'b1)) uCsSync (
        .clock   (clock),
        .reset_n (reset_n),
        .asyncIn (convStart_n),
        .syncOut (csSync)
    );
    asrp_sync3 #(.RESET_VAL(1'b0)) uClkSync (
        .clock   (clock),
        .reset_n (reset_n),
        .asyncIn (serialClk),
        .syncOut (sclkSync)
    );

    wire csFall   = csPrev_q & ~csSync;
    wire csRise   = ~csPrev_q & csSync;
    wire sclkFall = sclkPrev_q & ~sclkSync;
    wire sclkRise = ~sclkPrev_q & sclkSync;
    // an early rise that will enter partial or full power-down this very cycle
    wire goingDown = active_q & csRise & ~csFall &
                     (fallCnt_q < `ASRP_PD_EDGES) &
                     ~((fallCnt_q < `ASRP_GLITCH_EDGES) & powerMode[0]);

    // edge history of the filtered pins
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            csPrev_q   <= 1'b1;
            sclkPrev_q <= 1'b0;
        end else begin
            csPrev_q   <= csSync;
            sclkPrev_q <= sclkSync;
        end
    end

    // frame sequencing: bit shifting, counting and mode changes
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fallCnt_q       <= 5'h00;
            shift_q         <= 12'h000;
            active_q        <= 1'b0;
            serialResultOut <= 1'b0;
            serialResultOe  <= 1'b0;
            trackMode       <= 1'b1;
            sampleStrobe    <= 1'b0;
            powerMode       <= `ASRP_MODE_NORMAL;
            wokeFromFull_q  <= 1'b0;
            firstEdgeSeen_q <= 1'b0;
        end else begin
            sampleStrobe <= 1'b0;
            if (csFall) begin
                // hold, sample, leave three-state, first zero out [RL9] [RL20]
                active_q        <= 1'b1;
                fallCnt_q       <= 5'h00;
                shift_q         <= sampleValue;
                serialResultOut <= 1'b0;
                serialResultOe  <= 1'b1;
                trackMode       <= 1'b0;
                sampleStrobe    <= 1'b1;
                firstEdgeSeen_q <= 1'b0;
                wokeFromFull_q  <= powerMode[2];
            end else if (active_q && csRise) begin
                // early rise decides the next power state
                active_q       <= 1'b0;
                serialResultOe <= 1'b0;   // [RL11] [RL14] [RL19] [RL26]
                serialResultOut <= 1'b0;
                trackMode      <= 1'b1;
                if (fallCnt_q < `ASRP_GLITCH_EDGES &&
                        powerMode[0]) begin
                    powerMode <= `ASRP_MODE_NORMAL;   // [RL23]
                end else if (fallCnt_q < `ASRP_PD_EDGES) begin
                    if (powerMode[0]) begin
                        powerMode <= `ASRP_MODE_PARTIAL;   // [RL24] [RL17]
                    end else begin
                        powerMode <= `ASRP_MODE_FULL;      // [RL25]
                    end
                end else begin
                    powerMode <= `ASRP_MODE_NORMAL;   // [RL26]
                end
            end else if (active_q) begin
                if (sclkFall) begin
                    fallCnt_q <= fallCnt_q + 5'd1;   // [RL27]
                    // tenth fall completes the dummy wake-up [RL1]
                    if (fallCnt_q + 5'd1 == `ASRP_PD_EDGES) begin
                        powerMode <= `ASRP_MODE_NORMAL;
                    end
                    if (fallCnt_q + 5'd1 >= `ASRP_FRAME_LEN) begin
                        // release on the 16th fall [RL12] [RL15] [RL18]
                        serialResultOe  <= 1'b0;
                        serialResultOut <= 1'b0;
                        active_q        <= 1'b0;
                    end else if (fallCnt_q == 5'h00) begin
                        serialResultOut <= 1'b0;   // second lead zero
                    end else if (fallCnt_q < CONV_CLKS - 5'd1) begin
                        // result msb first, last bit by 15th fall [RL21]
                        serialResultOut <= shift_q[11];
                        shift_q <= {shift_q[10:0], 1'b0};
                    end else begin
                        // trailing zeros [RL12] [RL15] [RL18]
                        serialResultOut <= 1'b0;
                    end
                end
                // partial wake: track on first clock edge [RL4]
                if ((sclkFall | sclkRise) && !firstEdgeSeen_q) begin
                    firstEdgeSeen_q <= 1'b1;
                    if (powerMode[1]) begin
                        trackMode <= 1'b1;
                    end
                end
                // back to track after the conversion [RL10] [RL13] [RL16]
                if (sclkRise && fallCnt_q >= TRACK_AFTER) begin
                    trackMode <= 1'b1;
                end
            end
        end
    end

    // full power-down wake timer, about one microsecond
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            puCnt_q      <= 8'h00;
            fullyPowered <= 1'b1;
        end else begin
            if (csFall && powerMode[2]) begin
                puCnt_q      <= PU_CYC;
                fullyPowered <= 1'b0;
            end else if (!powerMode[0] || goingDown) begin
                // drop ready with the mode, not a cycle later [RL24]
                fullyPowered <= 1'b0;
            end else if (puCnt_q != 8'h00) begin
                puCnt_q <= puCnt_q - 8'h01;
            end else begin
                fullyPowered <= ~(wokeFromFull_q & active_q);
            end
        end
    end
endmodule // asrp_readout

// file: tb/asrp_readout_asserts.sv
// pin-level assertions on the readout block
`timescale 1ns/1ps
`include "asrp_consts.vh"
module asrp_readout_chk (
    input wire        clock,           // block clock
    input wire        reset_n,         // async reset
    input wire        convStart_n,     // start pin
    input wire        serialClk,       // serial clock pin
    input wire [11:0] sampleValue,     // core result
    input wire        serialResultOut, // data value
    input wire        serialResultOe,  // data enable
    input wire        trackMode,       // track state
    input wire        sampleStrobe,    // sample pulse
    input wire [2:0]  powerMode,       // power state
    input wire        fullyPowered     // analog ready
);
    // pin sync costs a few clocks, hence the short ranges
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    oe_start_a: assert property (
        $fell(convStart_n) |-> ##[3:8] serialResultOe)
        else $error("data line not driven after start");
    start_sample_a: assert property (
        $rose(serialResultOe) |-> sampleStrobe && !trackMode && !serialResultOut)
        else $error("start did not hold and show zero");
    strobe_pulse_a: assert property (
        sampleStrobe |=> !sampleStrobe)
        else $error("sample pulse too long");
    release_rise_a: assert property (
        $rose(convStart_n) |-> ##[3:8] !serialResultOe)
        else $error("data line kept after start rise");
    drive_pin_a: assert property (
        $rose(serialResultOe) |-> !convStart_n)
        else $error("data line driven with start high");
    mode_hot_a: assert property (
        $onehot(powerMode))
        else $error("power state not one-hot");
    down_unready_a: assert property (
        powerMode != `ASRP_MODE_NORMAL |-> !fullyPowered)
        else $error("ready flag high while down");
    down_on_rise_a: assert property (
        $changed(powerMode) && !powerMode[0] |-> convStart_n)
        else $error("power-down without start rise");
    cover property (sampleStrobe);
    cover property ($fell(powerMode[0]));
    cover property (powerMode[2]);
endmodule // asrp_readout_chk
bind asrp_readout asrp_readout_chk chk (.clock, .reset_n, .convStart_n,
    .serialClk, .sampleValue, .serialResultOut, .serialResultOe,
    .trackMode, .sampleStrobe, .powerMode, .fullyPowered);

// file: tb/asrp_host.sv
// host serial master model: start line and 400 ns serial clock
`timescale 1ns/1ps
module asrp_host (
    input  wire clock,                // paces the pins
    output reg  convStart_n = 1'b1,   // start line, idle high
    output reg  serialClk   = 1'b1,   // stands still between frames
    input  wire serialResultOut,      // data value
    input  wire serialResultOe        // data enable
);
    // released line floats, so a late enable never reads as data
    wire line = serialResultOe ? serialResultOut : 1'bz;
    // one frame of a given number of falling edges
    task frame(input integer falls, output reg [15:0] got);
        integer k;
        begin
            got = 16'h0;
            @(posedge clock) convStart_n <= 1'b0;
            repeat (8) @(posedge clock);
            for (k = 0; k < falls; k = k + 1) begin
                got[15-k] = line; // read after the rise
                serialClk <= 1'b0;
                repeat (4) @(posedge clock);
                serialClk <= 1'b1;
                repeat (4) @(posedge clock);
            end
            convStart_n <= 1'b1;
            repeat (12) @(posedge clock); // quiet time
        end
    endtask
endmodule // asrp_host

// file: tb/asrp_readout_tb.sv
// self-checking bench for the readout block
`timescale 1ns/1ps
`include "asrp_consts.vh"
module asrp_readout_tb;
    reg         clock       = 1'b0;
    reg         reset_n     = 1'b0;
    reg  [11:0] sampleValue = 12'ha5c;
    wire        convStart_n, serialClk, serialResultOut, serialResultOe;
    wire        trackMode, sampleStrobe, fullyPowered;
    wire [2:0]  powerMode;
    reg  [15:0] got;
    integer     failures = 0;
    integer     checks   = 0;
    always #25 clock = ~clock;
    asrp_readout dut (.clock, .reset_n, .convStart_n, .serialClk,
        .sampleValue, .serialResultOut, .serialResultOe, .trackMode,
        .sampleStrobe, .powerMode, .fullyPowered);
    asrp_host host (.clock, .convStart_n, .serialClk, .serialResultOut,
        .serialResultOe);
    // compare and count
    task chk(input string what, input [15:0] exp, input [15:0] seen);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected %s: expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // zeros, result msb first, zeros, release at the 16th fall
    task t_frame16;
        begin
            host.frame(16, got);
            chk("frame", {2'b00, sampleValue, 2'b00}, got);
            chk("oe", 16'h0, {15'h0, serialResultOe});
            chk("track", 16'h1, {15'h0, trackMode});
        end
    endtask
    // 14-clock frame: trailing zeros dropped, line released
    task t_frame14;
        begin
            host.frame(14, got);
            chk("f14", {2'b00, sampleValue}, got[15:2]);
            chk("oe", 16'h0, {15'h0, serialResultOe});
        end
    endtask
    // rise before the second fall keeps full power
    task t_glitch;
        begin
            host.frame(1, got);
            chk("mode", {13'h0, `ASRP_MODE_NORMAL}, {13'h0, powerMode});
        end
    endtask
    // rise after the tenth fall aborts but stays powered
    task t_abort;
        begin
            host.frame(12, got);
            chk("head", {4'h0, 2'b00, sampleValue[11:2]}, {4'h0, got[15:4]});
            chk("mode", {13'h0, `ASRP_MODE_NORMAL}, {13'h0, powerMode});
            chk("oe", 16'h0, {15'h0, serialResultOe});
        end
    endtask
    // two short frames: partial, then full power-down
    task t_power_down;
        begin
            // frames far apart, well below 600 kSPS
            host.frame(5, got);
            chk("mode", {13'h0, `ASRP_MODE_PARTIAL}, {13'h0, powerMode});
            chk("oe", 16'h0, {15'h0, serialResultOe});
            host.frame(5, got);
            chk("mode", {13'h0, `ASRP_MODE_FULL}, {13'h0, powerMode});
        end
    endtask
    // dummy frame wakes the part, then the wake time passes
    task t_wake;
        begin
            host.frame(16, got);
            chk("mode", {13'h0, `ASRP_MODE_NORMAL}, {13'h0, powerMode});
            repeat (24) @(posedge clock);
            chk("ready", 16'h1, {15'h0, fullyPowered});
        end
    endtask
    task conclude;
        begin
            if (failures == 0 && checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // watchdog: the whole sequence needs about 880 clocks
    initial begin
        repeat (4000) @(posedge clock);
        failures = failures + 1;
        conclude;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_frame16;
        t_frame14;
        t_glitch;
        t_abort;
        t_power_down;
        t_wake;
        sampleValue <= 12'h3c1;
        t_frame16;
        conclude;
    end
endmodule // asrp_readout_tb
